// *** eiu_det_if.sv ***
`timescale 1ns/1ps
// ==========================================================
// Control and result of the nonmaskable pin detector
interface eiu_det_if;
	import eiu_pkg::*;
	logic [SENSE_W-1:0] sense;
	logic               filt_en;
	logic               level;
	logic               detect;
	modport ctrl (output sense, output filt_en, input level, input detect);
	modport det  (input sense, input filt_en, output level, output detect);
endinterface

// *** eiu_nmi_det.sv ***
`timescale 1ns/1ps
// ==========================================================
// Pin synchroniser, filter and sense match
module eiu_nmi_det
	import eiu_pkg::*;
#(
	parameter int FLEN = FILT_LEN
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	eiu_det_if.det    dbus
);
	logic            s1_r;
	logic            s2_r;
	logic            s3_r;
	logic            stable_r;
	logic [FLEN-1:0] hist_r;
	logic            lvl_r;
	logic            prev_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts only once two late stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			stable_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			stable_r <= s3_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hist_r <= '0;
		end else begin
			hist_r <= {hist_r[FLEN-2:0], stable_r};
		end
	end

	// Filter costs FLEN cycles of latency but rejects short glitches
	always_ff @(posedge clk) begin
		if (rst) begin
			lvl_r <= 1'b0;
		end else if (!dbus.filt_en) begin
			lvl_r <= stable_r;
		end else if (&hist_r) begin
			lvl_r <= 1'b1;
		end else if (~|hist_r) begin
			lvl_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= lvl_r;
		end
	end

	assign dbus.level = lvl_r;

	always_comb begin
		unique case (dbus.sense)
			SENSE_NONE: dbus.detect = 1'b0;
			SENSE_RISE: dbus.detect = lvl_r & ~prev_r;
			SENSE_FALL: dbus.detect = ~lvl_r & prev_r;
			SENSE_BOTH: dbus.detect = lvl_r ^ prev_r;
			SENSE_HIGH: dbus.detect = lvl_r;
			SENSE_LOW: dbus.detect = ~lvl_r;
			default: dbus.detect = 1'b0;
		endcase
	end
endmodule

// *** eiu_pins_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Far side: nonmaskable pin, line detectors, line flags
module eiu_pins_model
	import eiu_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          nmi_cmd,
	input  wire logic [eiu_pkg::NUM_LINES-1:0] det_cmd,
	input  wire logic [eiu_pkg::NUM_LINES-1:0] flag_cmd,
	output logic                               nmi_pin,
	output logic [eiu_pkg::NUM_LINES-1:0]      line_detect,
	output logic [eiu_pkg::NUM_LINES-1:0]      line_flag
);
	logic [NUM_LINES-1:0] det_q_r;

	// ==========================================================
	// Detectors
	// One pulse per commanded rising bit; a held command never repeats
	always_ff @(posedge clk) begin
		if (rst) begin
			det_q_r     <= '0;
			line_detect <= '0;
		end else begin
			det_q_r     <= det_cmd;
			line_detect <= det_cmd & ~det_q_r;
		end
	end

	// ==========================================================
	// Pin and flag levels
	always_ff @(posedge clk) begin
		if (rst) begin
			nmi_pin   <= 1'h0;
			line_flag <= '0;
		end else begin
			nmi_pin   <= nmi_cmd;
			line_flag <= flag_cmd;
		end
	end
endmodule

// *** eiu_pkg.sv ***
// ==========================================================
// Register map
package eiu_pkg;
	localparam int         NUM_LINES      = 16;
	localparam int         ADDR_W         = 12;
	localparam int         DATA_W         = 32;

	// Printed offsets are indices; byte address is four times the index
	localparam logic [7:0] IDX_NMI_CTRL   = 8'h02;
	localparam logic [7:0] IDX_NMI_FLAG   = 8'h03;
	localparam logic [7:0] IDX_EVT_CTRL   = 8'h04;
	localparam logic [7:0] IDX_IE_CLEAR   = 8'h08;
	localparam logic [7:0] IDX_IE_SET     = 8'h0c;

	localparam logic [ADDR_W-1:0] ADDR_NMI_CTRL = {2'b00, IDX_NMI_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_NMI_FLAG = {2'b00, IDX_NMI_FLAG, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_EVT_CTRL = {2'b00, IDX_EVT_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IE_CLEAR = {2'b00, IDX_IE_CLEAR, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_IE_SET   = {2'b00, IDX_IE_SET, 2'b00};

	// ==========================================================
	// Field layout
	localparam int         FILT_BIT       = 3;
	localparam int         SENSE_LSB      = 0;
	localparam int         SENSE_W        = 3;
	localparam int         FLAG_BIT       = 0;

	// ==========================================================
	// Sense encodings
	localparam logic [SENSE_W-1:0] SENSE_NONE = 3'h0;
	localparam logic [SENSE_W-1:0] SENSE_RISE = 3'h1;
	localparam logic [SENSE_W-1:0] SENSE_FALL = 3'h2;
	localparam logic [SENSE_W-1:0] SENSE_BOTH = 3'h3;
	localparam logic [SENSE_W-1:0] SENSE_HIGH = 3'h4;
	localparam logic [SENSE_W-1:0] SENSE_LOW  = 3'h5;

	// ==========================================================
	// Reset values and timing
	localparam logic [7:0]           RST_NMI_CTRL = 8'h00;
	localparam logic [7:0]           RST_NMI_FLAG = 8'h00;
	localparam logic [NUM_LINES-1:0] RST_EVT_CTRL = 16'h0000;
	localparam logic [NUM_LINES-1:0] RST_IE       = 16'h0000;
	localparam int                   FILT_LEN     = 3;
endpackage

// *** eiu_top.sv ***
`timescale 1ns/1ps
// Operation
// - Bit 3 of nonmaskable control enables the input filter.
// - Sense codes 0..3: none, rising, falling, both edges.
// - Sense 4 high level, 5 low level; 6 and 7 reserved, no detect.
// - A sense match sets the nonmaskable flag and request, no enable.
// - Writing one to flag bit 0 clears it; zero leaves it.
// - One event output enable per line in low 16 bits.
// - Enabled line produces an event on each detection, else none.
// - Writing one to enable-clear clears that line enable.
// - Reading enable-clear returns current line enables.
// - Nonmaskable control resets to zero.
// - Event control and line enables reset to zero.
// - Line flag requests an interrupt only while enabled.
// - Writing one to enable-set sets that line enable.
module eiu_top
	import eiu_pkg::*;
(
	input  wire logic                          MCLK,
	input  wire logic                          RST,
	input  wire logic                          PSEL,
	input  wire logic                          PENABLE,
	input  wire logic                          PWRITE,
	input  wire logic [eiu_pkg::ADDR_W-1:0]    PADDR,
	input  wire logic [eiu_pkg::DATA_W-1:0]    PWDATA,
	input  wire logic [3:0]                    PSTRB,
	output logic                               PREADY,
	output logic [eiu_pkg::DATA_W-1:0]         PRDATA,
	output logic                               PSLVERR,
	input  wire logic                          WPROT_ACTIVE,
	input  wire logic                          NMI_PIN,
	input  wire logic [eiu_pkg::NUM_LINES-1:0] LINE_DETECT,
	input  wire logic [eiu_pkg::NUM_LINES-1:0] LINE_FLAG,
	output logic                               NMI_IRQ,
	output logic [eiu_pkg::NUM_LINES-1:0]      LINE_EVENT,
	output logic [eiu_pkg::NUM_LINES-1:0]      LINE_IRQ
);
	import eiu_pkg::*;

	// ==========================================================
	// Declarations
	logic                 filt_en_r;
	logic [SENSE_W-1:0]   sense_r;
	logic                 nmi_flag_r;
	logic                 nmi_flag_nxt;
	logic [NUM_LINES-1:0] evt_en_r;
	logic [NUM_LINES-1:0] ie_r;
	logic [NUM_LINES-1:0] ie_nxt;
	logic                 pready_r;
	logic [DATA_W-1:0]    prdata_r;
	logic [DATA_W-1:0]    rd_nxt;
	logic                 pslverr_r;
	logic                 nmi_irq_r;
	logic [NUM_LINES-1:0] line_evt_r;
	logic [NUM_LINES-1:0] line_irq_r;
	logic                 setup;
	logic                 wr_fire;
	logic                 wr_prot_ok;
	logic                 sel_ctrl;
	logic                 sel_flag;
	logic                 sel_evt;
	logic                 sel_clr;
	logic                 sel_set;
	logic                 mapped;
	logic [NUM_LINES-1:0] lane_m;
	logic [NUM_LINES-1:0] wr_bits;

	eiu_det_if dif ();

	eiu_nmi_det #(
		.FLEN (FILT_LEN)
	) u_det (
		.clk  (MCLK),
		.rst  (RST),
		.pin  (NMI_PIN),
		.dbus (dif.det)
	);

	assign dif.sense   = sense_r;
	assign dif.filt_en = filt_en_r;

	// ==========================================================
	// APB decode
	assign sel_ctrl   = (PADDR == ADDR_NMI_CTRL);
	assign sel_flag   = (PADDR == ADDR_NMI_FLAG);
	assign sel_evt    = (PADDR == ADDR_EVT_CTRL);
	assign sel_clr    = (PADDR == ADDR_IE_CLEAR);
	assign sel_set    = (PADDR == ADDR_IE_SET);
	assign mapped     = sel_ctrl | sel_flag | sel_evt | sel_clr | sel_set;
	assign setup      = PSEL & ~PENABLE;
	assign wr_fire    = PSEL & PENABLE & pready_r & PWRITE & mapped;
	assign wr_prot_ok = wr_fire & ~WPROT_ACTIVE;
	assign lane_m     = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
	assign wr_bits    = PWDATA[NUM_LINES-1:0] & lane_m;

	// One wait-free access phase: answer is prepared during setup
	always_ff @(posedge MCLK) begin
		if (RST) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= setup;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			pslverr_r <= 1'b0;
		end else begin
			pslverr_r <= setup & ~mapped;
		end
	end

	always_comb begin
		rd_nxt = '0;
		if (sel_ctrl) begin
			rd_nxt[FILT_BIT]                      = filt_en_r;
			rd_nxt[SENSE_LSB +: SENSE_W]          = sense_r;
		end else if (sel_flag) begin
			rd_nxt[FLAG_BIT]                      = nmi_flag_r;
		end else if (sel_evt) begin
			rd_nxt[NUM_LINES-1:0]                 = evt_en_r;
		end else if (sel_clr | sel_set) begin
			rd_nxt[NUM_LINES-1:0]                 = ie_r;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			prdata_r <= '0;
		end else if (setup & ~PWRITE) begin
			prdata_r <= rd_nxt;
		end
	end

	// ==========================================================
	// Nonmaskable control
	always_ff @(posedge MCLK) begin
		if (RST) begin
			filt_en_r <= RST_NMI_CTRL[FILT_BIT];
			sense_r   <= RST_NMI_CTRL[SENSE_LSB +: SENSE_W];
		end else if (wr_prot_ok & sel_ctrl & PSTRB[0]) begin
			filt_en_r <= PWDATA[FILT_BIT];
			sense_r   <= PWDATA[SENSE_LSB +: SENSE_W];
		end
	end

	// ==========================================================
	// Nonmaskable flag: a new match wins over a clear
	always_comb begin
		nmi_flag_nxt = nmi_flag_r;
		if (wr_fire & sel_flag & PSTRB[0] & PWDATA[FLAG_BIT]) begin
			nmi_flag_nxt = 1'b0;
		end
		if (dif.detect) begin
			nmi_flag_nxt = 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			nmi_flag_r <= RST_NMI_FLAG[FLAG_BIT];
		end else begin
			nmi_flag_r <= nmi_flag_nxt;
		end
	end

	// Request tracks the flag with no enable in the way
	always_ff @(posedge MCLK) begin
		if (RST) begin
			nmi_irq_r <= 1'b0;
		end else begin
			nmi_irq_r <= nmi_flag_nxt;
		end
	end

	// ==========================================================
	// Event output enables
	always_ff @(posedge MCLK) begin
		if (RST) begin
			evt_en_r <= RST_EVT_CTRL;
		end else if (wr_prot_ok & sel_evt) begin
			evt_en_r <= (evt_en_r & ~lane_m) | wr_bits;
		end
	end

	// ==========================================================
	// Line interrupt enables, set and clear views
	always_comb begin
		ie_nxt = ie_r;
		if (wr_prot_ok & sel_clr) begin
			ie_nxt = ie_r & ~wr_bits;
		end else if (wr_prot_ok & sel_set) begin
			ie_nxt = ie_r | wr_bits;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			ie_r <= RST_IE;
		end else begin
			ie_r <= ie_nxt;
		end
	end

	// ==========================================================
	// Per-line event and request gating
	for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
		always_ff @(posedge MCLK) begin
			if (RST) begin
				line_evt_r[g] <= 1'b0;
				line_irq_r[g] <= 1'b0;
			end else begin
				line_evt_r[g] <= LINE_DETECT[g] & evt_en_r[g];
				line_irq_r[g] <= LINE_FLAG[g] & ie_r[g];
			end
		end
	end

	assign PREADY     = pready_r;
	assign PRDATA     = prdata_r;
	assign PSLVERR    = pslverr_r;
	assign NMI_IRQ    = nmi_irq_r;
	assign LINE_EVENT = line_evt_r;
	assign LINE_IRQ   = line_irq_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);

	filt_write_a: assert property (
		wr_fire & sel_ctrl & PSTRB[0] & ~WPROT_ACTIVE
		|=> filt_en_r == $past(PWDATA[FILT_BIT]))
		else $error("filter enable not written");

	sense_none_a: assert property (
		sense_r == SENSE_NONE |-> !dif.detect)
		else $error("detect with sense none");

	sense_edge_a: assert property (
		sense_r == SENSE_RISE & dif.level & !$past(dif.level) & $stable(sense_r)
		|-> dif.detect)
		else $error("rising edge missed");

	sense_level_a: assert property (
		(sense_r == SENSE_HIGH & dif.level) | (sense_r == SENSE_LOW & !dif.level)
		|-> dif.detect)
		else $error("level match missed");

	sense_resv_a: assert property (
		sense_r > SENSE_LOW |-> !dif.detect)
		else $error("detect on reserved sense");

	nmi_raise_a: assert property (
		dif.detect |=> nmi_flag_r & NMI_IRQ)
		else $error("match did not raise flag and request");

	nmi_clear_a: assert property (
		wr_fire & sel_flag & PSTRB[0] & PWDATA[FLAG_BIT] & !dif.detect
		|=> !nmi_flag_r ##1 (!nmi_flag_r || $past(dif.detect)))
		else $error("flag clear failed");

	nmi_keep_a: assert property (
		nmi_flag_r & wr_fire & sel_flag & !PWDATA[FLAG_BIT] |=> nmi_flag_r)
		else $error("zero write cleared flag");

	evt_gate_a: assert property (
		LINE_EVENT == ($past(LINE_DETECT) & $past(evt_en_r)))
		else $error("event gating wrong");

	ie_clear_a: assert property (
		wr_fire & sel_clr & ~WPROT_ACTIVE & PSTRB[0] & PWDATA[0] |=> !ie_r[0])
		else $error("enable clear failed");

	ie_set_a: assert property (
		wr_fire & sel_set & ~WPROT_ACTIVE & PSTRB[0] & PWDATA[0] |=> ie_r[0])
		else $error("enable set failed");

	ie_read_a: assert property (
		setup & ~PWRITE & sel_clr ##1 PENABLE & !$changed(ie_r)
		|-> PRDATA[NUM_LINES-1:0] == ie_r && PREADY)
		else $error("enable readback wrong");

	irq_gate_a: assert property (
		!ie_r[0] |=> !LINE_IRQ[0])
		else $error("request while disabled");

	wprot_hold_a: assert property (
		wr_fire & WPROT_ACTIVE |=> $stable(evt_en_r) & $stable(ie_r) & $stable(sense_r))
		else $error("protected register written");

	reset_zero_a: assert property (
		$past(RST) |-> !filt_en_r & sense_r == SENSE_NONE & evt_en_r == '0 & ie_r == '0)
		else $error("reset values wrong");

	irq_flag_eq_a: assert property (
		NMI_IRQ == nmi_flag_r)
		else $error("request differs from flag");

	flag_rise_a: assert property (
		!nmi_flag_r & !dif.detect |=> !nmi_flag_r)
		else $error("flag rose without a match");

	sense_fall_a: assert property (
		sense_r == SENSE_FALL & !dif.level & $past(dif.level) & $stable(sense_r)
		|-> dif.detect)
		else $error("falling edge missed");

	ctrl_write_a: assert property (
		wr_prot_ok & sel_ctrl & PSTRB[0]
		|=> sense_r == $past(PWDATA[SENSE_LSB +: SENSE_W]))
		else $error("sense select not written");

	ctrl_hold_a: assert property (
		!(wr_prot_ok & sel_ctrl & PSTRB[0]) |=> $stable(sense_r) & $stable(filt_en_r))
		else $error("control changed without a write");

	evt_write_a: assert property (
		wr_prot_ok & sel_evt & (PSTRB[1:0] == 2'h3)
		|=> evt_en_r == $past(PWDATA[NUM_LINES-1:0]))
		else $error("event enables not written");

	evt_hold_a: assert property (
		!(wr_prot_ok & sel_evt) |=> $stable(evt_en_r))
		else $error("event enables changed without a write");

	ie_clear_all_a: assert property (
		wr_prot_ok & sel_clr |=> (ie_r & $past(wr_bits)) == '0)
		else $error("enable clear missed a line");

	ie_set_all_a: assert property (
		wr_prot_ok & sel_set |=> (ie_r & $past(wr_bits)) == $past(wr_bits))
		else $error("enable set missed a line");

	ie_hold_a: assert property (
		!(wr_prot_ok & (sel_clr | sel_set)) |=> $stable(ie_r))
		else $error("enables changed without a write");

	irq_full_a: assert property (
		LINE_IRQ == ($past(LINE_FLAG) & $past(ie_r)))
		else $error("line request gating wrong");

	reset_out_a: assert property (
		$past(RST) |-> !NMI_IRQ & (LINE_EVENT == '0) & (LINE_IRQ == '0))
		else $error("outputs not cleared by reset");

	cov_nmi_c:   cover property (dif.detect ##1 wr_fire & sel_flag & PWDATA[FLAG_BIT]);
	cov_evt_c:   cover property (|LINE_EVENT);
	cov_irq_c:   cover property (|LINE_IRQ);
	cov_prot_c:  cover property (wr_fire & WPROT_ACTIVE & sel_evt);
	cov_race_c:  cover property (dif.detect & wr_fire & sel_flag & PWDATA[FLAG_BIT]);
endmodule

// *** eiu_top_tb.sv ***
`timescale 1ns/1ps
module eiu_top_tb;
	import eiu_pkg::*;
	typedef struct {
		logic [ADDR_W-1:0] wa;
		logic [DATA_W-1:0] wd;
		logic [ADDR_W-1:0] ra;
		logic [DATA_W-1:0] ex;
	} eiu_row_t;
	localparam int LIMIT = 20000;
	logic                 mclk;
	logic                 rst;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [ADDR_W-1:0]    paddr;
	logic [DATA_W-1:0]    pwdata;
	logic                 pready;
	logic [DATA_W-1:0]    prdata;
	logic                 pslverr;
	logic [3:0]           pstrb;
	logic                 wprot;
	logic                 nmi_cmd;
	logic                 nmi_pin;
	logic                 nmi_irq;
	logic [NUM_LINES-1:0] det_cmd;
	logic [NUM_LINES-1:0] flag_cmd;
	logic [NUM_LINES-1:0] line_detect;
	logic [NUM_LINES-1:0] line_flag;
	logic [NUM_LINES-1:0] line_event;
	logic [NUM_LINES-1:0] line_irq;
	logic [NUM_LINES-1:0] acc;
	logic [DATA_W-1:0]    rdat;
	logic                 rerr;
	logic [SENSE_W-1:0]   sn;
	eiu_row_t             rows [5];
	int                   pulses;
	int                   cycles;
	int                   fail_count;
	int                   n_compared;

	eiu_top u_eiu_top (
		.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata),
		.PSLVERR(pslverr), .WPROT_ACTIVE(wprot), .NMI_PIN(nmi_pin),
		.LINE_DETECT(line_detect), .LINE_FLAG(line_flag), .NMI_IRQ(nmi_irq),
		.LINE_EVENT(line_event), .LINE_IRQ(line_irq)
	);
	eiu_pins_model u_eiu_pins_model (
		.clk(mclk), .rst(rst), .nmi_cmd(nmi_cmd), .det_cmd(det_cmd), .flag_cmd(flag_cmd),
		.nmi_pin(nmi_pin), .line_detect(line_detect), .line_flag(line_flag)
	);

	// ==========================================================
	// Clock, timeout, verdict
	initial mclk = 1'h0;
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fail_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ==========================================================
	// Compare and bus tasks
	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Waits on pready itself; only the bench timeout ends a hung wait
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
		@(posedge mclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
		apb(1'h0, a, 32'h0);
		check(rdat, ex);
		check_bit(rerr, 1'h0);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 47'h0};
		{wprot, nmi_cmd, det_cmd, flag_cmd, cycles, fail_count, n_compared} = '0;
		rows[0] = '{ADDR_NMI_CTRL, 32'h0000000b, ADDR_NMI_CTRL, 32'h0000000b};
		rows[1] = '{ADDR_EVT_CTRL, 32'hffffffff, ADDR_EVT_CTRL, 32'h0000ffff};
		rows[2] = '{ADDR_IE_SET, 32'h0000a5a5, ADDR_IE_CLEAR, 32'h0000a5a5};
		rows[3] = '{ADDR_IE_CLEAR, 32'h00000005, ADDR_IE_CLEAR, 32'h0000a5a0};
		rows[4] = '{ADDR_IE_CLEAR, 32'h0000ffff, ADDR_IE_SET, 32'h00000000};
		pstrb = 4'hf;
		cyc(12);
		rst <= 1'h0;
		rdchk(ADDR_NMI_CTRL, 32'h0);
		rdchk(ADDR_EVT_CTRL, 32'h0);
		rdchk(ADDR_IE_CLEAR, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].wa, rows[i].wd);
			rdchk(rows[i].ra, rows[i].ex);
		end
		for (int c = 0; c < 8; c++) begin
			sn = 3'(c);
			wr(ADDR_NMI_CTRL, 32'h0);
			cyc(8);
			wr(ADDR_NMI_FLAG, 32'h1);
			wr(ADDR_NMI_CTRL, {29'h0, sn});
			cyc(8);
			check_bit(nmi_irq, sn == SENSE_LOW);
			nmi_cmd <= 1'h1;
			cyc(8);
			check_bit(nmi_irq, sn inside {SENSE_RISE, SENSE_BOTH, SENSE_HIGH, SENSE_LOW});
			wr(ADDR_NMI_FLAG, 32'h1);
			cyc(2);
			check_bit(nmi_irq, sn == SENSE_HIGH);
			nmi_cmd <= 1'h0;
			cyc(8);
			check_bit(nmi_irq, sn inside {SENSE_FALL, SENSE_BOTH, SENSE_HIGH, SENSE_LOW});
		end
		// A flag stays up after a zero write, then clears on a one
		wr(ADDR_NMI_CTRL, 32'h1);
		wr(ADDR_NMI_FLAG, 32'h1);
		nmi_cmd <= 1'h1;
		cyc(8);
		wr(ADDR_NMI_FLAG, 32'h0);
		rdchk(ADDR_NMI_FLAG, 32'h1);
		wr(ADDR_NMI_FLAG, 32'h1);
		cyc(2);
		check_bit(nmi_irq, 1'h0);
		nmi_cmd <= 1'h0;
		// Short pulse: seen unfiltered, swallowed by the filter
		for (int f = 1; f >= 0; f--) begin
			wr(ADDR_NMI_CTRL, {28'h0, f[0], 3'h1});
			cyc(10);
			nmi_cmd <= 1'h1;
			cyc(2);
			nmi_cmd <= 1'h0;
			cyc(10);
			check_bit(nmi_irq, f == 0);
			wr(ADDR_NMI_FLAG, 32'h1);
		end
		apb(1'h1, 12'h040, 32'hffffffff);
		check_bit(rerr, 1'h1);
		apb(1'h0, 12'h040, 32'h0);
		check(rdat, 32'h0);
		// Protected writes must leave the old contents in place
		wprot <= 1'h1;
		wr(ADDR_EVT_CTRL, 32'h0);
		wr(ADDR_IE_SET, 32'h0000ffff);
		wr(ADDR_NMI_CTRL, 32'h0000000c);
		rdchk(ADDR_EVT_CTRL, 32'h0000ffff);
		rdchk(ADDR_IE_CLEAR, 32'h0);
		rdchk(ADDR_NMI_CTRL, 32'h00000001);
		wprot <= 1'h0;
		// Events: one pulse per detection, enabled lines only
		wr(ADDR_EVT_CTRL, 32'h000000ff);
		det_cmd <= 16'hffff;
		acc = '0;
		pulses = 0;
		repeat (6) begin
			@(posedge mclk);
			acc = acc | line_event;
			pulses = pulses + int'(line_event != '0);
		end
		check({16'h0, acc}, 32'h000000ff);
		check_bit(pulses == 1, 1'h1);
		det_cmd <= '0;
		wr(ADDR_IE_SET, 32'h000000f0);
		flag_cmd <= 16'h0ff0;
		cyc(4);
		check({16'h0, line_irq}, 32'h000000f0);
		wr(ADDR_IE_CLEAR, 32'h00000010);
		cyc(2);
		check({16'h0, line_irq}, 32'h000000e0);
		// Lane 1 alone: the low byte of the enables is kept
		pstrb <= 4'h2;
		wr(ADDR_EVT_CTRL, 32'h0000ab00);
		pstrb <= 4'hf;
		rdchk(ADDR_EVT_CTRL, 32'h0000abff);
		rst <= 1'h1;
		cyc(2);
		rst <= 1'h0;
		rdchk(ADDR_NMI_CTRL, 32'h0);
		rdchk(ADDR_EVT_CTRL, 32'h0);
		rdchk(ADDR_IE_CLEAR, 32'h0);
		check({16'h0, line_irq}, 32'h0);
		test_done();
	end
endmodule
